// ===== hw/pcst_qdiv.sv
// Quarter instruction cycle enable divider.
// Assumes clr comes from logic on the same clock; qen is a one-cycle pulse.
`default_nettype none
module pcst_qdiv
    import pcst_pkg::*;
#(
    parameter int DIV = QUARTER_CLKS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Phase restart and quarter pulse.
    input wire logic clr,
    output logic qen
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic qen_r;
    logic qen_nxt;

    // A restart puts the count back to zero so phases line up with the access.
    always_comb begin
        cnt_nxt = (clr || cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        qen_nxt = !clr && (cnt_r == LAST);
    end

    // Registers of the divider.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            qen_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            qen_r <= qen_nxt;
        end
    end

    assign qen = qen_r;
endmodule
`default_nettype wire

// ===== hw/pcst_timing.sv
// Chip select strobe timer with a Wishbone classic register slave.
// Assumes external data and acknowledge pins are asynchronous to clk.
`default_nettype none
module pcst_timing
    import pcst_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16,
    parameter int QDIV = QUARTER_CLKS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External parallel port.
    output logic pm_cs_n,
    output logic pm_rd_strobe,
    output logic pm_wr_strobe,
    output logic [AW-1:0] pm_addr,
    output logic [DW-1:0] pm_data_o,
    output logic pm_data_oe,
    input wire logic [DW-1:0] pm_data_i,
    input wire logic external_acknowledge_input
);
    logic qen;
    logic start_go;

    // Bus side registers.
    logic [15:0] chip_select_mode_timing_r, chip_select_mode_timing_nxt;
    logic [AW-1:0] addr_reg_r, addr_reg_nxt;
    logic [DW-1:0] wdata_r, wdata_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic timeout_r, timeout_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic go_wr_r, go_wr_nxt;

    // Access engine registers.
    pcst_state_t state_r, state_nxt;
    logic [10:0] cnt_r, cnt_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic wr_r, wr_nxt;
    logic cs_n_r, cs_n_nxt;
    logic rds_r, rds_nxt;
    logic wrs_r, wrs_nxt;
    logic [AW-1:0] pa_r, pa_nxt;
    logic [DW-1:0] pd_r, pd_nxt;
    logic oe_r, oe_nxt;
    logic to_evt;
    logic rd_cap;

    // Pin synchronisers.
    logic [DW-1:0] din_m_r, din_s_r;
    logic ack_m_r, ack_s_r;

    // Field views of the latched configuration.
    logic [1:0] f_setup, f_hold, f_ackm;
    logic [3:0] f_strobe;
    logic ack_mode;
    assign f_setup = cfg_r[POS_SETUP +: 2];
    assign f_strobe = cfg_r[POS_STROBE +: 4];
    assign f_hold = cfg_r[POS_HOLD +: 2];
    assign f_ackm = cfg_r[POS_ACK_MODE +: 2];
    assign ack_mode = (f_ackm == ACK_MODE_TIMEOUT);

    logic bus_req, bus_wr, bus_rd;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign bus_wr = bus_req && wb_we_i;
    assign bus_rd = bus_req && !wb_we_i;
    assign start_go = bus_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]
                      && wb_dat_i[POS_CTRL_START] && (state_r == PCST_IDLE);

    // Quarter-cycle phase source, restarted at each access.
    pcst_qdiv #(.DIV(QDIV)) u_qdiv (
        .clk(clk),
        .rst(rst),
        .clr(start_go),
        .qen(qen)
    );

    // Two flip-flop synchronisers for the external data and acknowledge pins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_m_r <= '0;
            din_s_r <= '0;
            ack_m_r <= 1'b0;
            ack_s_r <= 1'b0;
        end else begin
            din_m_r <= pm_data_i;
            din_s_r <= din_m_r;
            ack_m_r <= external_acknowledge_input;
            ack_s_r <= ack_m_r;
        end
    end

    // Register file: decode, byte-lane writes, read mux and single-cycle ack.
    always_comb begin
        chip_select_mode_timing_nxt = chip_select_mode_timing_r;
        addr_reg_nxt = addr_reg_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rd_cap ? din_s_r : rdata_r;
        timeout_nxt = timeout_r;
        go_wr_nxt = go_wr_r;
        ack_nxt = bus_req;
        dat_nxt = 32'h0000_0000;
        if (bus_wr) begin
            unique case (wb_adr_i)
                OFS_MODE_TIMING: chip_select_mode_timing_nxt =
                    pcst_merge(chip_select_mode_timing_r, wb_dat_i, wb_sel_i) & MODE_TIMING_MASK;
                OFS_ADDR: addr_reg_nxt = AW'(pcst_merge(16'(addr_reg_r), wb_dat_i, wb_sel_i));
                OFS_WDATA: wdata_nxt = DW'(pcst_merge(16'(wdata_r), wb_dat_i, wb_sel_i));
                OFS_CTRL: if (start_go) begin
                    go_wr_nxt = wb_dat_i[POS_CTRL_WRITE];
                end
                OFS_STATUS: if (wb_sel_i[0] && wb_dat_i[POS_STAT_TIMEOUT]) begin
                    timeout_nxt = 1'b0;
                end
                default: ;
            endcase
        end
        // A new time-out wins over a clear in the same cycle.
        if (to_evt) begin
            timeout_nxt = 1'b1;
        end
        if (bus_rd) begin
            unique case (wb_adr_i)
                OFS_MODE_TIMING: dat_nxt = {16'h0000, chip_select_mode_timing_r};
                OFS_CTRL: dat_nxt = {30'h0, go_wr_r, state_r != PCST_IDLE};
                OFS_ADDR: dat_nxt = 32'(addr_reg_r);
                OFS_WDATA: dat_nxt = 32'(wdata_r);
                OFS_RDATA: dat_nxt = 32'(rdata_r);
                OFS_STATUS: dat_nxt = {30'h0, timeout_r, state_r != PCST_IDLE};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Registers of the bus slave.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_select_mode_timing_r <= RST_MODE_TIMING;
            addr_reg_r <= AW'(RST_WORD);
            wdata_r <= DW'(RST_WORD);
            rdata_r <= DW'(RST_WORD);
            timeout_r <= 1'b0;
            go_wr_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            chip_select_mode_timing_r <= chip_select_mode_timing_nxt;
            addr_reg_r <= addr_reg_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            timeout_r <= timeout_nxt;
            go_wr_r <= go_wr_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Access sequencer: counts quarter phases through setup, strobe and hold.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        wr_nxt = wr_r;
        pa_nxt = pa_r;
        pd_nxt = pd_r;
        to_evt = 1'b0;
        rd_cap = 1'b0;
        unique case (state_r)
            PCST_IDLE: if (start_go) begin
                cfg_nxt = chip_select_mode_timing_r;
                wr_nxt = wb_dat_i[POS_CTRL_WRITE];
                pa_nxt = addr_reg_r;
                pd_nxt = wdata_r;
                cnt_nxt = pcst_setup_q(chip_select_mode_timing_r[POS_SETUP +: 2]);
                state_nxt = PCST_SETUP;
            end
            PCST_SETUP: if (qen) begin
                if (cnt_r == 11'h001) begin
                    cnt_nxt = ack_mode ? pcst_ack_limit_q(f_strobe)
                                       : pcst_strobe_q(f_strobe, wr_r);
                    state_nxt = PCST_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 11'h001;
                end
            end
            PCST_STROBE: if (qen) begin
                if (cnt_r == 11'h001 || (ack_mode && ack_s_r)) begin
                    to_evt = ack_mode && !ack_s_r;
                    rd_cap = !wr_r;
                    cnt_nxt = pcst_hold_q(f_hold, wr_r);
                    state_nxt = (pcst_hold_q(f_hold, wr_r) == 11'h000) ? PCST_IDLE
                                                                       : PCST_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 11'h001;
                end
            end
            PCST_HOLD: if (qen) begin
                if (cnt_r == 11'h001) begin
                    state_nxt = PCST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 11'h001;
                end
            end
        endcase
        cs_n_nxt = (state_nxt == PCST_IDLE);
        rds_nxt = (state_nxt == PCST_STROBE) && !wr_nxt;
        wrs_nxt = (state_nxt == PCST_STROBE) && wr_nxt;
        oe_nxt = (state_nxt != PCST_IDLE) && wr_nxt;
    end

    // Registers of the sequencer and the pin drivers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= PCST_IDLE;
            cnt_r <= 11'h000;
            cfg_r <= RST_MODE_TIMING;
            wr_r <= 1'b0;
            pa_r <= '0;
            pd_r <= '0;
            cs_n_r <= 1'b1;
            rds_r <= 1'b0;
            wrs_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            wr_r <= wr_nxt;
            pa_r <= pa_nxt;
            pd_r <= pd_nxt;
            cs_n_r <= cs_n_nxt;
            rds_r <= rds_nxt;
            wrs_r <= wrs_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign pm_cs_n = cs_n_r;
    assign pm_rd_strobe = rds_r;
    assign pm_wr_strobe = wrs_r;
    assign pm_addr = pa_r;
    assign pm_data_o = pd_r;
    assign pm_data_oe = oe_r;

    // Helper for the checks: quarter pulses seen in the current phase.
    logic [10:0] phq_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phq_r <= 11'h000;
        end else begin
            phq_r <= (state_nxt != state_r) ? 11'h000 : phq_r + {10'h000, qen};
        end
    end
    logic leave;
    assign leave = (state_nxt != state_r) && (state_r != PCST_IDLE);

    property p_setup_len;
        @(posedge clk) disable iff (rst)
        (leave && state_r == PCST_SETUP) |-> (phq_r + 11'h001 == {7'h00, f_setup, 2'b01});
    endproperty
    a_setup_len: assert property (p_setup_len) else $error("setup length wrong");

    property p_wr_strobe_len;
        @(posedge clk) disable iff (rst)
        (leave && state_r == PCST_STROBE && wr_r && !ack_mode)
            |-> (phq_r + 11'h001 == {5'h00, f_strobe, 2'b10});
    endproperty
    a_wr_strobe_len: assert property (p_wr_strobe_len) else $error("write strobe wrong");

    property p_rd_strobe_len;
        @(posedge clk) disable iff (rst)
        (leave && state_r == PCST_STROBE && !wr_r && !ack_mode)
            |-> (phq_r + 11'h001 == {5'h00, f_strobe, 2'b11});
    endproperty
    a_rd_strobe_len: assert property (p_rd_strobe_len) else $error("read strobe wrong");

    property p_wr_hold_len;
        @(posedge clk) disable iff (rst)
        (leave && state_r == PCST_HOLD && wr_r) |-> (phq_r + 11'h001 == pcst_hold_q(f_hold, 1'b1));
    endproperty
    a_wr_hold_len: assert property (p_wr_hold_len) else $error("write hold wrong");

    property p_rd_hold_len;
        @(posedge clk) disable iff (rst)
        (leave && state_r == PCST_STROBE && !wr_r)
            |-> ((f_hold == 2'h0) == (state_nxt == PCST_IDLE));
    endproperty
    a_rd_hold_len: assert property (p_rd_hold_len) else $error("read hold skip wrong");

    property p_ack_limit;
        @(posedge clk) disable iff (rst)
        (state_r == PCST_STROBE && ack_mode) |-> (phq_r < pcst_ack_limit_q(f_strobe));
    endproperty
    a_ack_limit: assert property (p_ack_limit) else $error("ack wait past limit");

    property p_order;
        @(posedge clk) disable iff (rst)
        $rose(state_r == PCST_STROBE) |-> $past(state_r) == PCST_SETUP;
    endproperty
    a_order: assert property (p_order) else $error("strobe not after setup");

    property p_pins;
        @(posedge clk) disable iff (rst)
        (pm_rd_strobe || pm_wr_strobe) |-> !pm_cs_n && !(pm_rd_strobe && pm_wr_strobe);
    endproperty
    a_pins: assert property (p_pins) else $error("strobe without chip select");

    property p_timeout_flag;
        @(posedge clk) disable iff (rst)
        to_evt |=> timeout_r;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("time-out not flagged");

    c_write: cover property (@(posedge clk) disable iff (rst) $fell(pm_wr_strobe));
    c_read: cover property (@(posedge clk) disable iff (rst) $fell(pm_rd_strobe));
    c_timeout: cover property (@(posedge clk) disable iff (rst) to_evt);
endmodule
`default_nettype wire

// ===== pkg/pcst_pkg.sv
// Constants, register map and timing helpers for the chip select strobe timer.
// Assumes a single 200 MHz clock and a Wishbone classic register bus.
// How it works
// - Setup before strobe lasts field cycles plus one quarter: 3.25, 2.25, 1.25, 0.25 cycles.
// - Write strobe lasts strobe field plus one half instruction cycle.
// - Read strobe lasts strobe field plus three quarters instruction cycle.
// - Write hold lasts 3.25, 2.25, 1.25, 1.25 cycles for codes 11 to 00.
// - Read hold lasts a whole number of cycles equal to the hold field.
// - In acknowledge mode a zero strobe field gives up after at most 255 cycles.
`default_nettype none
package pcst_pkg;
    // Clock and instruction cycle timing.
    localparam int CLK_NS = 5;
    localparam int TCY_NS = 80;
    localparam int QUARTER_CLKS = (TCY_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam int ACK_TIMEOUT_TCY = 255;
    localparam logic [10:0] ACK_TIMEOUT_Q = 11'(ACK_TIMEOUT_TCY * 4);
    localparam logic [10:0] WR_HOLD_ZERO_Q = 11'h005;

    // Register byte offsets.
    localparam logic [7:0] OFS_MODE_TIMING = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Reset values.
    localparam logic [15:0] RST_MODE_TIMING = 16'h0000;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Field positions in the chip select mode timing register.
    localparam int POS_ACK_MODE = 14;
    localparam int POS_ALT_WAIT = 11;
    localparam int POS_SETUP = 6;
    localparam int POS_STROBE = 2;
    localparam int POS_HOLD = 0;
    localparam logic [15:0] MODE_TIMING_MASK = 16'hF8FF;
    localparam logic [1:0] ACK_MODE_TIMEOUT = 2'h1;

    // Control and status bit positions.
    localparam int POS_CTRL_START = 0;
    localparam int POS_CTRL_WRITE = 1;
    localparam int POS_STAT_BUSY = 0;
    localparam int POS_STAT_TIMEOUT = 1;

    // Access phase encoding, one-hot.
    typedef enum logic [3:0] {
        PCST_IDLE = 4'b0001,
        PCST_SETUP = 4'b0010,
        PCST_STROBE = 4'b0100,
        PCST_HOLD = 4'b1000
    } pcst_state_t;

    // Setup time in quarter cycles.
    function automatic logic [10:0] pcst_setup_q(input logic [1:0] f);
        return {7'h00, f, 2'b01};
    endfunction

    // Strobe width in quarter cycles, write or read.
    function automatic logic [10:0] pcst_strobe_q(input logic [3:0] f, input logic wr);
        return wr ? {5'h00, f, 2'b10} : {5'h00, f, 2'b11};
    endfunction

    // Hold time in quarter cycles, write or read.
    function automatic logic [10:0] pcst_hold_q(input logic [1:0] f, input logic wr);
        if (wr) begin
            return (f == 2'h0) ? WR_HOLD_ZERO_Q : {7'h00, f, 2'b01};
        end
        return {7'h00, f, 2'b00};
    endfunction

    // Acknowledge wait limit in quarter cycles.
    function automatic logic [10:0] pcst_ack_limit_q(input logic [3:0] f);
        return (f == 4'h0) ? ACK_TIMEOUT_Q : {5'h00, f, 2'b00};
    endfunction

    // Byte-lane merge of a bus write into a 16-bit register.
    function automatic logic [15:0] pcst_merge(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction
endpackage
`default_nettype wire

// ===== verification/pcst_ext_mem.sv
// External 16-word parallel memory on one chip select.
// Assumes strobes are sampled on the device clock; acknowledge is bench controlled.
`default_nettype none
module pcst_ext_mem (
    // Clock.
    input wire logic clk,
    // Parallel port from the device.
    input wire logic cs_n,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic ack,
    // Acknowledge control.
    input wire logic ack_en,
    input wire logic [7:0] ack_dly
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [16];
    logic wr_q = 1'b0;
    int cnt = 0;

    // Start with a quiet bus and no acknowledge.
    initial begin
        rdata = 16'h0000;
        ack = 1'b0;
    end

    // Drive data only during a selected read; a released bus toggles so stale data never matches.
    always @(posedge clk) begin
        cnt <= (rd_strobe || wr_strobe) ? cnt + 1 : 0;
        rdata <= (!cs_n && rd_strobe) ? mem[addr[3:0]] : ~rdata;
        ack <= ack_en && !cs_n && (rd_strobe || wr_strobe) && cnt >= int'(ack_dly);
        wr_q <= wr_strobe;
        if (wr_q && !wr_strobe && !cs_n) begin
            mem[addr[3:0]] <= wdata;
        end
    end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the chip select strobe timer.
// Assumes the design answers each Wishbone request with a one-cycle ack.
`default_nettype none
module testbench
    import pcst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QD = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_ack_o, pm_cs_n, pm_rd_strobe, pm_wr_strobe, pm_data_oe, ack_pin;
    logic [15:0] pm_addr, pm_data_o, pm_data_i, a_q;
    logic ack_en = 1'b0, exp_wr = 1'b0, cs_q = 1'b1;
    logic [7:0] ack_dly = 8'h00;
    int failures = 0, checks = 0, cyc_n = 0;
    int setup_c = 0, strobe_c = 0, hold_c = 0, acc_n = 0, bad_c = 0;

    pcst_timing #(.QDIV(QD)) i_pcst_timing (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pm_cs_n(pm_cs_n), .pm_rd_strobe(pm_rd_strobe),
        .pm_wr_strobe(pm_wr_strobe), .pm_addr(pm_addr), .pm_data_o(pm_data_o),
        .pm_data_oe(pm_data_oe), .pm_data_i(pm_data_i), .external_acknowledge_input(ack_pin));

    pcst_ext_mem i_pcst_ext_mem (
        .clk(clk), .cs_n(pm_cs_n), .rd_strobe(pm_rd_strobe), .wr_strobe(pm_wr_strobe),
        .addr(pm_addr), .wdata(pm_data_o), .rdata(pm_data_i), .ack(ack_pin),
        .ack_en(ack_en), .ack_dly(ack_dly));

    // Clock generator.
    always #2.5 clk = ~clk;

    // Phase monitor: counts setup, strobe and hold cycles and flags anything out of order.
    always @(posedge clk) begin
        if (!pm_cs_n) begin
            if (cs_q) begin
                acc_n++;
                setup_c = 0;
                strobe_c = 0;
                hold_c = 0;
                a_q = pm_addr;
            end
            if (pm_rd_strobe || pm_wr_strobe) begin
                strobe_c++;
                if (hold_c != 0 || pm_rd_strobe === pm_wr_strobe || pm_wr_strobe !== exp_wr) begin
                    bad_c++;
                end
            end else if (strobe_c == 0) begin
                setup_c++;
            end else begin
                hold_c++;
            end
            if (pm_data_oe !== exp_wr || pm_addr !== a_q) begin
                bad_c++;
            end
        end else if (pm_rd_strobe || pm_wr_strobe || pm_data_oe) begin
            bad_c++;
        end
        cs_q = pm_cs_n;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            failures++;
            end_sim;
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and stops.
    task automatic end_sim;
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack is sampled.
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            failures++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    // Register write and read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, s, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb_cycle(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask

    // Polls busy until the access is over.
    task automatic wait_idle;
        logic [31:0] q;
        int n;
        n = 0;
        rd(OFS_STATUS, q);
        while (q[POS_STAT_BUSY] !== 1'b0 && n < 1500) begin
            rd(OFS_STATUS, q);
            n++;
        end
        if (n >= 1500) begin
            failures++;
        end
    endtask

    // Programs the timing and runs one access.
    task automatic run_acc(input logic w, input logic [1:0] am, input logic [1:0] s,
                           input logic [3:0] m, input logic [1:0] h, input logic [15:0] a,
                           input logic [15:0] d);
        int n0;
        n0 = acc_n;
        wr(OFS_MODE_TIMING, {16'h0000, am, 6'h00, s, m, h}, 4'h3);
        wr(OFS_ADDR, {16'h0000, a}, 4'h3);
        wr(OFS_WDATA, {16'h0000, d}, 4'h3);
        exp_wr = w;
        wr(OFS_CTRL, {30'h0000_0000, w, 1'b1}, 4'h1);
        wait_idle;
        check("access_count", acc_n - n0, 1);
        check("phase_order", bad_c, 0);
    endtask

    // Reset values, masked bits, byte lanes, read-only and unmapped places.
    task automatic t_regs;
        logic [31:0] q;
        rd(OFS_MODE_TIMING, q);
        check("mode_reset", q, {16'h0000, RST_MODE_TIMING});
        rd(OFS_STATUS, q);
        check("status_reset", q, 0);
        wr(OFS_MODE_TIMING, 32'hFFFF_FFFF, 4'hF);
        rd(OFS_MODE_TIMING, q);
        check("mode_mask", q, {16'h0000, MODE_TIMING_MASK});
        wr(OFS_MODE_TIMING, 32'h0000_1234, 4'h1);
        rd(OFS_MODE_TIMING, q);
        check("mode_lane", q, {16'h0000, MODE_TIMING_MASK[15:8], 8'h34});
        wr(8'h40, 32'h0000_FFFF, 4'hF);
        rd(8'h40, q);
        check("unmapped", q, 0);
        wr(OFS_RDATA, 32'h0000_FFFF, 4'h3);
        rd(OFS_RDATA, q);
        check("rdata_ro", q, 0);
    endtask

    // Every setup and hold code, strobe codes 0, 1, 5 and 15, writes then read-back.
    task automatic t_table;
        logic [1:0] sv [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
        logic [3:0] mv [4] = '{4'h0, 4'h1, 4'hF, 4'h5};
        logic [15:0] av [4] = '{16'h0001, 16'h0002, 16'hFFF3, 16'h0004};
        logic [15:0] dv [4] = '{16'h5AA5, 16'hA55A, 16'h0F0F, 16'hF0F0};
        logic [31:0] q;
        int hq;
        int sq;
        ack_en <= 1'b1;
        for (int w = 1; w >= 0; w--) begin
            for (int i = 0; i < 4; i++) begin
                run_acc(w[0], 2'h0, sv[i], mv[i], sv[3 - i], av[i], dv[i]);
                sq = (sv[i] * 4 + 1) * QD;
                hq = w ? ((sv[3 - i] == 2'h0) ? 5 : sv[3 - i] * 4 + 1) : sv[3 - i] * 4;
                check("setup_len", setup_c inside {[sq : sq + 1]}, 1);
                check("strobe_len", strobe_c, (mv[i] * 4 + (w ? 2 : 3)) * QD);
                check("hold_len", hold_c, hq * QD);
                if (w == 0) begin
                    rd(OFS_RDATA, q);
                    check("read_data", q, {16'h0000, dv[i]});
                end
            end
        end
    endtask

    // Acknowledge mode: early answer, then silence until the time-out.
    task automatic t_ack;
        logic [31:0] q;
        ack_dly <= 8'h04;
        run_acc(1'b0, ACK_MODE_TIMEOUT, 2'h0, 4'h0, 2'h0, 16'h0001, 16'h0000);
        check("ack_end", strobe_c inside {[5 : 16]}, 1);
        rd(OFS_STATUS, q);
        check("no_timeout", q[POS_STAT_TIMEOUT], 0);
        ack_en <= 1'b0;
        run_acc(1'b1, ACK_MODE_TIMEOUT, 2'h0, 4'h0, 2'h0, 16'h0005, 16'h1234);
        check("timeout_len", strobe_c inside {[1019 * QD : 1020 * QD + 1]}, 1);
        rd(OFS_STATUS, q);
        check("timeout_flag", q[POS_STAT_TIMEOUT], 1);
        wr(OFS_STATUS, 32'h0000_0002, 4'h1);
        rd(OFS_STATUS, q);
        check("timeout_clear", q, 0);
        run_acc(1'b0, ACK_MODE_TIMEOUT, 2'h0, 4'h2, 2'h0, 16'h0002, 16'h0000);
        check("limit_len", strobe_c, 8 * QD);
        rd(OFS_STATUS, q);
        check("limit_flag", q[POS_STAT_TIMEOUT], 1);
        wr(OFS_STATUS, 32'h0000_0002, 4'h1);
    endtask

    // A start while busy is ignored; one access runs to the end.
    task automatic t_busy;
        logic [31:0] q;
        int n0;
        n0 = acc_n;
        wr(OFS_MODE_TIMING, 32'h0000_003C, 4'h3);
        exp_wr = 1'b1;
        wr(OFS_CTRL, 32'h0000_0003, 4'h1);
        rd(OFS_STATUS, q);
        check("busy_set", q[POS_STAT_BUSY], 1);
        wr(OFS_CTRL, 32'h0000_0001, 4'h1);
        wait_idle;
        check("one_access", acc_n - n0, 1);
        check("busy_order", bad_c, 0);
        rd(OFS_CTRL, q);
        check("last_dir", q[POS_CTRL_WRITE], 1);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_table;
        t_ack;
        t_busy;
        end_sim;
    end
endmodule
`default_nettype wire
